/* File: design/fdl_loader.sv */
`timescale 1ns/10ps
module fdl_loader #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Running application identifier
  input wire logic [7:0] appId,
  // Host register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Download hardware
  output logic dlInit,
  output logic [7:0] dlSeed,
  // System control
  output logic ramRemap,
  output logic sysResetReq,
  // Program fetch port
  input wire logic [AW-1:0] fetchAddr,
  output logic [7:0] fetchData,
  // Loader state
  output logic [15:0] ramPointer,
  output logic busy
);
  fdl_pkg::fdl_state_t state;
  logic [7:0] cmdStatus;
  logic [7:0] command;
  logic [7:0] payloadLength;
  logic [7:0] checkByte;
  logic [7:0] payload [fdl_pkg::PAYLOAD_BYTES];
  logic [7:0] sumAcc;
  logic [7:0] index;
  logic loaderOpen;
  logic hostWrite;
  logic inPayload;
  logic [6:0] payloadSlot;
  logic ramWrEn;
  logic [AW-1:0] ramWrAddr;
  logic [7:0] ramWrData;
  logic [7:0] next_sum;

  fdl_ram_if #(.AW(AW)) ramBus ();

  fdl_ram #(.AW(AW)) ram (
    .mclk(mclk),
    .srst(srst),
    .port(ramBus)
  );

  assign ramBus.wrEn = ramWrEn;
  assign ramBus.wrAddr = ramWrAddr;
  assign ramBus.wrData = ramWrData;
  assign ramBus.rdAddr = fetchAddr;
  assign fetchData = ramBus.rdData;

  // The loader window only exists while the loader application runs.
  assign loaderOpen = (appId == fdl_pkg::LOADER_APPID); // see R1
  // Writes while a command runs are dropped so the image stays coherent.
  assign hostWrite = regWrite && loaderOpen && (state == fdl_pkg::ST_IDLE);
  assign inPayload = (regAddr >= fdl_pkg::OFS_PAYLOAD_FIRST) &&
                     (regAddr <= fdl_pkg::OFS_PAYLOAD_LAST); // see R3
  assign payloadSlot = 7'(regAddr - fdl_pkg::OFS_PAYLOAD_FIRST);
  assign next_sum = 8'(sumAcc + payload[index[6:0]]); // see R15

  // Host-written parameter registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      payloadLength <= fdl_pkg::RST_PAYLOAD_LENGTH;
      checkByte <= fdl_pkg::RST_CHECK_BYTE;
    end else if (hostWrite) begin
      if (regAddr == fdl_pkg::OFS_PAYLOAD_LENGTH) begin
        // Bit 7 is kept so a full 128-byte write can be sized.
        payloadLength <= regWrData; // see R3
      end
      if (regAddr == fdl_pkg::OFS_CHECK_BYTE) begin
        checkByte <= regWrData; // see R4
      end
    end
  end

  // Payload window, one byte per address.
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < fdl_pkg::PAYLOAD_BYTES; i++) begin
        payload[i] <= fdl_pkg::RST_PAYLOAD;
      end
    end else if (hostWrite && inPayload) begin
      payload[payloadSlot] <= regWrData; // see R3
    end
  end

  // Command sequencer: sum the frame, verify, then execute.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= fdl_pkg::ST_IDLE;
      cmdStatus <= fdl_pkg::RST_CMD_STATUS;
      command <= 8'h00;
      sumAcc <= 8'h00;
      index <= 8'h00;
    end else begin
      unique case (state)
        fdl_pkg::ST_IDLE: begin
          if (hostWrite && regAddr == fdl_pkg::OFS_CMD_STATUS) begin
            command <= regWrData; // see R2
            index <= 8'h00;
            if (payloadLength > fdl_pkg::PAYLOAD_MAX) begin
              cmdStatus <= fdl_pkg::STAT_ERR_SIZE;
            end else begin
              sumAcc <= 8'(regWrData + payloadLength); // see R4, R15
              cmdStatus <= fdl_pkg::STAT_BUSY;
              state <= fdl_pkg::ST_SUM;
            end
          end
        end
        fdl_pkg::ST_SUM: begin
          if (index == payloadLength) begin
            state <= fdl_pkg::ST_EXEC;
          end else begin
            sumAcc <= next_sum; // see R4
            index <= 8'(index + 8'h01);
          end
        end
        fdl_pkg::ST_EXEC: begin
          index <= 8'h00;
          state <= fdl_pkg::ST_IDLE;
          if ((sumAcc ^ fdl_pkg::CHECK_INVERT) != checkByte) begin
            cmdStatus <= fdl_pkg::STAT_ERR_CHECK; // see R4, R16
          end else begin
            unique case (command)
              fdl_pkg::CMD_REMAP_RESTART: begin
                cmdStatus <= (payloadLength == fdl_pkg::LEN_REMAP) ?
                             fdl_pkg::STAT_OK : fdl_pkg::STAT_ERR_SIZE;
              end
              fdl_pkg::CMD_DOWNLOAD_INIT: begin
                cmdStatus <= (payloadLength == fdl_pkg::LEN_INIT) ?
                             fdl_pkg::STAT_OK : fdl_pkg::STAT_ERR_SIZE;
              end
              fdl_pkg::CMD_MEM_POINTER: begin
                cmdStatus <= (payloadLength == fdl_pkg::LEN_POINTER) ?
                             fdl_pkg::STAT_OK : fdl_pkg::STAT_ERR_SIZE;
              end
              fdl_pkg::CMD_MEM_WRITE: begin
                if (payloadLength == 8'h00) begin
                  cmdStatus <= fdl_pkg::STAT_ERR_SIZE;
                end else begin
                  state <= fdl_pkg::ST_WRITE; // see R9
                end
              end
              default: begin
                cmdStatus <= fdl_pkg::STAT_ERR_CMD; // see R16
              end
            endcase
          end
        end
        fdl_pkg::ST_WRITE: begin
          index <= 8'(index + 8'h01);
          if (index == 8'(payloadLength - 8'h01)) begin
            cmdStatus <= fdl_pkg::STAT_OK;
            state <= fdl_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // A command in its execute cycle whose check byte verifies; length is checked at each use.
  logic execGood;
  assign execGood = (state == fdl_pkg::ST_EXEC) &&
                    ((sumAcc ^ fdl_pkg::CHECK_INVERT) == checkByte);

  // RAM pointer; only a good pointer or write command moves it.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ramPointer <= fdl_pkg::RST_RAM_POINTER;
    end else if (execGood && command == fdl_pkg::CMD_MEM_POINTER &&
                 payloadLength == fdl_pkg::LEN_POINTER) begin
      ramPointer <= {payload[1], payload[0]}; // see R12, R13
    end else if (state == fdl_pkg::ST_WRITE &&
                 index == 8'(payloadLength - 8'h01)) begin
      ramPointer <= 16'(ramPointer + {8'h00, payloadLength}); // see R10
    end
  end

  // RAM write stream, one byte per cycle from the pointer upward.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ramWrEn <= 1'b0;
      ramWrAddr <= '0;
      ramWrData <= 8'h00;
    end else begin
      ramWrEn <= (state == fdl_pkg::ST_WRITE); // see R9
      ramWrAddr <= AW'(ramPointer + {8'h00, index}); // see R13
      ramWrData <= payload[index[6:0]];
    end
  end

  // Download hardware seed.
  always_ff @(posedge mclk) begin
    if (srst) begin
      dlInit <= 1'b0;
      dlSeed <= 8'h00;
    end else begin
      dlInit <= 1'b0;
      if (execGood && command == fdl_pkg::CMD_DOWNLOAD_INIT &&
          payloadLength == fdl_pkg::LEN_INIT) begin
        dlInit <= 1'b1; // see R8
        dlSeed <= payload[0];
      end
    end
  end

  // Remap and restart acts in the verify cycle with no further wait. The
  // remap level is not cleared by the loader's own reset, because the
  // system reset it requests must not undo the remap.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sysResetReq <= 1'b0;
    end else begin
      sysResetReq <= execGood && command == fdl_pkg::CMD_REMAP_RESTART &&
                     payloadLength == fdl_pkg::LEN_REMAP; // see R5, R6
    end
  end

  logic remapSeen;
  always_ff @(posedge mclk) begin
    if (srst && !remapSeen) begin
      ramRemap <= 1'b0;
    end else if (execGood && command == fdl_pkg::CMD_REMAP_RESTART &&
                 payloadLength == fdl_pkg::LEN_REMAP) begin
      ramRemap <= 1'b1; // see R5, R6
    end
  end
  assign remapSeen = ramRemap;

  // Register read-back, one cycle after the read strobe.
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= 8'h00;
      if (loaderOpen) begin // see R1
        if (regAddr == fdl_pkg::OFS_CMD_STATUS) begin
          regRdData <= cmdStatus; // see R2
        end else if (regAddr == fdl_pkg::OFS_PAYLOAD_LENGTH) begin
          regRdData <= {1'b0, payloadLength[fdl_pkg::LENGTH_MSB:0]};
        end else if (inPayload) begin
          regRdData <= payload[payloadSlot];
        end else if (regAddr == fdl_pkg::OFS_CHECK_BYTE) begin
          regRdData <= checkByte;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != fdl_pkg::ST_IDLE) ||
              (hostWrite && regAddr == fdl_pkg::OFS_CMD_STATUS);
    end
  end
endmodule

/* File: design/fdl_pkg.sv */
// Overview of operation
// R1 - Loader registers are visible only while the running application id is 0x80.
// R2 - Writing the command register starts a command; reading returns status, zero means ok.
// R3 - Length holds a 7-bit byte count; payload window takes up to 128 bytes. The loader also keeps bit 7 and reads back bits 6:0 only.
// R4 - Check byte equals inverted sum of command, length and payload; device verifies it.
// R5 - Command 0x11 with no payload maps RAM to zero and resets the system.
// R6 - Remap and restart acts at once so the RAM program runs straight after.
// R7 - Host recovers a device with no valid RAM program by a hardware reset. The loader's srst does not clear ramRemap once it is set.
// R8 - Command 0x14 with one byte seeds and initialises the download hardware.
// R9 - Command 0x41 stores one to 128 payload bytes in RAM at the pointer.
// R10 - After a good memory write the pointer moves just past the written bytes.
// R11 - Host sets the RAM pointer before any memory write.
// R12 - Command 0x43 with two bytes loads the pointer, low byte first.
// R13 - The pointer set is where the next memory read or write starts.
// R14 - Host writes the check byte straight after the last payload byte.
// R15 - The checksum sum is taken modulo 256 before inversion.
// R16 - Bad command or checksum leaves RAM and pointer alone and sets nonzero status.
package fdl_pkg;
  localparam logic [7:0] LOADER_APPID = 8'h80;

  // Register offsets on the host register port.
  localparam logic [7:0] OFS_CMD_STATUS = 8'h08;
  localparam logic [7:0] OFS_PAYLOAD_LENGTH = 8'h09;
  localparam logic [7:0] OFS_PAYLOAD_FIRST = 8'h0a;
  localparam logic [7:0] OFS_PAYLOAD_LAST = 8'h89;
  localparam logic [7:0] OFS_CHECK_BYTE = 8'h8b;

  // Field layout and reset values.
  localparam int LENGTH_MSB = 6;
  localparam logic [7:0] RST_CMD_STATUS = 8'h00;
  localparam logic [7:0] RST_PAYLOAD_LENGTH = 8'h00;
  localparam logic [7:0] RST_PAYLOAD = 8'h00;
  localparam logic [7:0] RST_CHECK_BYTE = 8'h00;
  localparam logic [15:0] RST_RAM_POINTER = 16'h0000;

  localparam int PAYLOAD_BYTES = 128;
  localparam logic [7:0] PAYLOAD_MAX = 8'h80;
  localparam logic [7:0] CHECK_INVERT = 8'hff;

  // Command codes.
  localparam logic [7:0] CMD_REMAP_RESTART = 8'h11;
  localparam logic [7:0] CMD_DOWNLOAD_INIT = 8'h14;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h41;
  localparam logic [7:0] CMD_MEM_POINTER = 8'h43;

  localparam logic [7:0] LEN_REMAP = 8'h00;
  localparam logic [7:0] LEN_INIT = 8'h01;
  localparam logic [7:0] LEN_POINTER = 8'h02;

  // Status codes; every nonzero value is an error or still busy.
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_BUSY = 8'h01;
  localparam logic [7:0] STAT_ERR_CHECK = 8'h02;
  localparam logic [7:0] STAT_ERR_CMD = 8'h03;
  localparam logic [7:0] STAT_ERR_SIZE = 8'h04;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SUM,
    ST_EXEC,
    ST_WRITE
  } fdl_state_t;
endpackage

/* File: design/fdl_ram_if.sv */
`timescale 1ns/10ps
interface fdl_ram_if #(
  parameter int AW = 10
);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [7:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [7:0] rdData;

  modport loader (output wrEn, output wrAddr, output wrData, output rdAddr,
                  input rdData);
  modport ram (input wrEn, input wrAddr, input wrData, input rdAddr,
               output rdData);
endinterface

/* File: design/fdl_ram.sv */
`timescale 1ns/10ps
module fdl_ram #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Loader side
  fdl_ram_if.ram port
);
  localparam int DEPTH = 1 << AW;

  logic [7:0] mem [DEPTH];
  logic [7:0] rdData;

  // The program image survives a system reset so the remapped code can run.
  always_ff @(posedge mclk) begin
    if (port.wrEn) begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= mem[port.rdAddr];
    end
  end

  assign port.rdData = rdData;
endmodule

/* File: verif/fdl_loader_monitor.sv */
`timescale 1ns/10ps
module fdl_loader_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] appId,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Loader outputs
  input wire logic dlInit,
  input wire logic [7:0] dlSeed,
  input wire logic ramRemap,
  input wire logic sysResetReq,
  input wire logic [15:0] ramPointer,
  input wire logic busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence cmdWrite;
    regWrite && regAddr == 8'h08 && appId == 8'h80 && !busy;
  endsequence
  // A full 128 byte write needs about 260 cycles.
  sequence cmdRun;
    busy ##[1:300] !busy;
  endsequence
  chk_cmd_starts: assert property (cmdWrite |=> cmdRun)
    else $error("Command write did not run a command.");
  chk_closed_reads: assert property (
    regRead && appId != 8'h80 |=> regRdData == 8'h00)
    else $error("Closed window read not zero.");
  chk_gap_reads: assert property (
    regRead && regAddr == 8'h8a |=> regRdData == 8'h00)
    else $error("Gap address read not zero.");
  // Busy falls one cycle after the sequencer is done, so only a read with
  // busy still high a cycle later is sure to see the busy code.
  chk_busy_status: assert property (
    regRead && !regWrite && regAddr == 8'h08 && appId == 8'h80 && busy
    ##1 busy |-> regRdData == 8'h01) else $error("Busy status not shown.");
  chk_read_holds: assert property (
    !regRead |=> $stable(regRdData))
    else $error("Read data moved without a read.");
  chk_init_pulse: assert property (dlInit |=> !dlInit)
    else $error("Init pulse too long.");
  chk_seed_moves: assert property (
    !$past(srst) && $changed(dlSeed) |-> dlInit)
    else $error("Seed changed without init.");
  chk_remap_first: assert property (
    sysResetReq |-> ramRemap ##1 !sysResetReq)
    else $error("Restart without remap.");
  chk_remap_sticky: assert property (ramRemap |=> ramRemap)
    else $error("Remap dropped.");
  chk_ptr_by_cmd: assert property (
    !$past(srst) && $changed(ramPointer) |-> $past(busy))
    else $error("Pointer moved idle.");
endmodule
bind fdl_loader fdl_loader_monitor u_fdl_loader_monitor (.mclk(mclk),
  .srst(srst), .appId(appId), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .dlInit(dlInit),
  .dlSeed(dlSeed), .ramRemap(ramRemap), .sysResetReq(sysResetReq),
  .ramPointer(ramPointer), .busy(busy));

/* File: verif/fdl_host.sv */
`timescale 1ns/10ps
module fdl_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWrData,
  output logic regRead,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWrData = 8'h00;
    regRead = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    regAddr = a;
    regWrData = v;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
    regWrData = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    v = regRdData;
  endtask
  // The command byte goes last because writing it starts the command.
  task automatic send(input logic [7:0] cmd, input logic [7:0] q[$],
                      input logic bad);
    logic [7:0] s;
    s = cmd + 8'(q.size());
    wr(8'h09, 8'(q.size()));
    foreach (q[i]) begin
      wr(8'h0a + 8'(i), q[i]);
      s = s + q[i];
    end
    wr(8'h8b, ~s ^ {7'h00, bad});
    wr(8'h08, cmd);
  endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/10ps
module tb;
  logic mclk;
  logic srst;
  logic [7:0] appId, regAddr, regWrData, regRdData, dlSeed, fetchData, d, st;
  logic regWrite, regRead, dlInit, ramRemap, sysResetReq, busy;
  logic [9:0] fetchAddr;
  logic [15:0] ramPointer, ptr;
  logic [7:0] q[$];
  logic [31:0] lfsr = 32'h00015af7;
  logic sawInit = 1'b0;
  logic sawReset = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int len;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  fdl_loader #(.AW(10)) u_fdl_loader (.mclk(mclk), .srst(srst), .appId(appId),
    .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
    .regRead(regRead), .regRdData(regRdData), .dlInit(dlInit),
    .dlSeed(dlSeed), .ramRemap(ramRemap), .sysResetReq(sysResetReq),
    .fetchAddr(fetchAddr), .fetchData(fetchData), .ramPointer(ramPointer),
    .busy(busy));
  fdl_host u_fdl_host (.mclk(mclk), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData));
  function logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input logic [7:0] cmd, input logic bad);
    int n;
    u_fdl_host.send(cmd, q, bad);
    u_fdl_host.rd(8'h08, st);
    chk("busy status", 8'h01, st);
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge mclk);
    chk("idle", 1'b0, busy);
    u_fdl_host.rd(8'h08, st);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (dlInit === 1'b1) sawInit <= 1'b1;
    if (sysResetReq === 1'b1) sawReset <= 1'b1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    srst = 1'b1;
    appId = 8'h00;
    fetchAddr = 10'h000;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    u_fdl_host.rd(8'h08, d);
    chk("status", 8'h00, d);
    u_fdl_host.wr(8'h09, 8'h05);
    u_fdl_host.rd(8'h09, d);
    chk("closed", 8'h00, d);
    appId = 8'h80;
    u_fdl_host.rd(8'h09, d);
    chk("dropped", 8'h00, d);
    u_fdl_host.wr(8'h09, 8'hff);
    u_fdl_host.rd(8'h09, d);
    chk("length", 8'h7f, d);
    u_fdl_host.wr(8'h8a, 8'ha5);
    u_fdl_host.rd(8'h8a, d);
    chk("gap", 8'h00, d);
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      ptr = {7'h00, d[0], rnd()};
      q = {ptr[7:0], ptr[15:8]};
      run(8'h43, 1'b0);
      chk("pointer", ptr, ramPointer);
      len = (k == 0) ? 1 : (k == 1) ? 128 : 1 + rnd() % 127;
      q = {};
      repeat (len) q.push_back(rnd());
      run(8'h41, 1'b0);
      chk("status", 8'h00, st);
      ptr = ptr + 16'(len);
      chk("advance", ptr, ramPointer);
      foreach (q[i]) begin
        fetchAddr = ptr[9:0] - 10'(len) + 10'(i);
        @(negedge mclk);
        chk("ram", q[i], fetchData);
      end
      $display("write test %0d done", k);
    end
    q = {8'h12, 8'h34, 8'h56};
    run(8'h41, 1'b1);
    chk("sum error", 8'h02, st);
    chk("kept", ptr, ramPointer);
    run(8'h55, 1'b0);
    chk("unknown", 8'h03, st);
    q = {8'h01};
    run(8'h43, 1'b0);
    chk("size", 8'h04, st);
    chk("size kept", ptr, ramPointer);
    d = rnd();
    q = {d};
    run(8'h14, 1'b0);
    chk("seed", d, dlSeed);
    chk("init", 1'b1, sawInit);
    chk("init status", 8'h00, st);
    $display("error test done");
    q = {};
    run(8'h11, 1'b0);
    chk("remap", 1'b1, ramRemap);
    chk("restart", 1'b1, sawReset);
    chk("remap status", 8'h00, st);
    $display("remap test done");
    // The host recovers the loader with a hardware reset after the remap command finishes.
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    u_fdl_host.rd(8'h08, st);
    chk("reset status", 8'h00, st);
    chk("reset pointer", 16'h0000, ramPointer);
    chk("remap kept", 1'b1, ramRemap);
    $display("recovery test done");
    final_report();
  end
endmodule
